// ### logic/brot_pkg.sv
// Summary of operation
// - Rotate-left: bit 7 wraps to bit 0; N,Z updated
// - Destination bit 0 selects W, 1 the file
// - Bank bit 0 access bank, 1 uses bank select
// - Extended set, bank bit 0, f<=5Fh: indexed offset
// - Rotate-right through carry; C,N,Z updated
package brot_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_WREG = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_BANK = 8'h0C;
    localparam logic [7:0] ADDR_CFG = 8'h10;
    localparam logic [7:0] ADDR_INDEX = 8'h14;
    localparam logic [7:0] ADDR_MEM_ADDR = 8'h18;
    localparam logic [7:0] ADDR_MEM_DATA = 8'h1C;

    ////////////////////////////////////////////////////////////////////////////
    // Instruction word layout
    localparam logic [5:0] OPC_ROTATE_LEFT_NO_CARRY = 6'h11;
    localparam logic [5:0] OPC_ROTATE_RIGHT_THRU_CARRY = 6'h0C;
    localparam int OPC_LSB = 10;
    localparam int DEST_BIT = 9;
    localparam int BANK_BIT = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Addressing
    localparam logic [7:0] ACCESS_SPLIT = 8'h5F;
    localparam logic [3:0] ACCESS_LOW_PAGE = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_PAGE = 4'hF;

    ////////////////////////////////////////////////////////////////////////////
    // Status and config register fields
    localparam int STAT_C_BIT = 0;
    localparam int STAT_Z_BIT = 2;
    localparam int STAT_N_BIT = 4;
    localparam int STAT_BAD_BIT = 7;
    localparam int CFG_EXT_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic CFG_EXT_RST = 1'b0;
    localparam logic [11:0] INDEX_RST = 12'h000;
    localparam logic [11:0] MEM_ADDR_RST = 12'h000;
    localparam logic [15:0] INSTR_RST = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : brot_pkg

// ### logic/brot_rotator.sv
`timescale 1ns/1ps
module brot_rotator
    import brot_pkg::*;
(
    input wire logic [7:0] src,
    input wire logic carry_in,
    input wire logic rotate_right,
    output logic [7:0] result,
    output logic carry_out,
    output logic negative,
    output logic zero
);

    always_comb begin
        if (rotate_right) begin
            result = {carry_in, src[7:1]};
            carry_out = src[0];
        end else begin
            result = {src[6:0], src[7]};
            carry_out = carry_in;
        end
        negative = result[7];
        zero = (result == 8'h00);
    end

endmodule : brot_rotator

// ### logic/brot_file_mem.sv
`timescale 1ns/1ps
module brot_file_mem
    import brot_pkg::*;
(
    input wire logic clk,
    input wire logic we,
    input wire logic [11:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [11:0] raddr_a,
    output logic [7:0] rdata_a,
    input wire logic [11:0] raddr_b,
    output logic [7:0] rdata_b
);

    // Data space has no reset; software loads it before use
    logic [7:0] mem [0:4095];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata_a = mem[raddr_a];
    assign rdata_b = mem[raddr_b];

endmodule : brot_file_mem

// ### logic/brot_core.sv
`timescale 1ns/1ps
module brot_core
    import brot_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic aw_held;
        logic [7:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] last_instr;
        logic [7:0] wreg;
        logic carry;
        logic zero;
        logic neg;
        logic bad_op;
        logic [3:0] bank;
        logic ext_en;
        logic [11:0] index_base;
        logic [11:0] mem_addr;
    } brot_state_t;

    brot_state_t st;
    brot_state_t next_st;

    logic [15:0] instr;
    logic [7:0] f_addr;
    logic is_rl;
    logic is_rr;
    logic dest_file;
    logic bank_sel;
    logic [11:0] eff_addr;
    logic [7:0] src_data;
    logic [7:0] rot_result;
    logic rot_carry;
    logic rot_neg;
    logic rot_zero;
    logic exec_fire;
    logic instr_taken;
    logic mem_we;
    logic [11:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic [7:0] status_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the held instruction word
    assign instr = st.w_data[15:0];
    assign f_addr = instr[7:0];
    assign is_rl = (instr[15:OPC_LSB] == OPC_ROTATE_LEFT_NO_CARRY);
    assign is_rr = (instr[15:OPC_LSB] == OPC_ROTATE_RIGHT_THRU_CARRY);
    assign dest_file = instr[DEST_BIT];
    assign bank_sel = instr[BANK_BIT];
    assign instr_taken = st.aw_held && st.w_held && !st.bvalid
        && (st.aw_addr[7:2] == ADDR_INSTR[7:2]) && (st.w_strb[1:0] == 2'b11);
    assign exec_fire = instr_taken && (is_rl || is_rr);

    always_comb begin
        if (bank_sel) begin
            eff_addr = {st.bank, f_addr};
        end else if (st.ext_en && (f_addr <= ACCESS_SPLIT)) begin
            eff_addr = 12'(st.index_base + {4'h0, f_addr});
        end else if (f_addr <= ACCESS_SPLIT) begin
            eff_addr = {ACCESS_LOW_PAGE, f_addr};
        end else begin
            eff_addr = {ACCESS_HIGH_PAGE, f_addr};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Datapath
    brot_rotator u_rot (
        .src(src_data),
        .carry_in(st.carry),
        .rotate_right(is_rr),
        .result(rot_result),
        .carry_out(rot_carry),
        .negative(rot_neg),
        .zero(rot_zero)
    );

    brot_file_mem u_mem (
        .clk(clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr_a(eff_addr),
        .rdata_a(src_data),
        .raddr_b(st.mem_addr),
        .rdata_b(mem_rdata)
    );

    always_comb begin
        status_byte = 8'h00;
        status_byte[STAT_C_BIT] = st.carry;
        status_byte[STAT_Z_BIT] = st.zero;
        status_byte[STAT_N_BIT] = st.neg;
        status_byte[STAT_BAD_BIT] = st.bad_op;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        next_st = st;
        mem_we = 1'b0;
        mem_waddr = eff_addr;
        mem_wdata = rot_result;
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // Write performed once both halves are held; response follows
        if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            case ({st.aw_addr[7:2], 2'b00})
                ADDR_INSTR: begin
                    if (st.w_strb[1:0] != 2'b11) begin
                        next_st.bresp = RESP_SLVERR;
                    end else if (is_rl || is_rr) begin
                        next_st.last_instr = instr;
                        next_st.bad_op = 1'b0;
                        next_st.neg = rot_neg;
                        next_st.zero = rot_zero;
                        if (is_rr) begin
                            next_st.carry = rot_carry;
                        end
                        if (dest_file) begin
                            mem_we = 1'b1;
                        end else begin
                            next_st.wreg = rot_result;
                        end
                    end else begin
                        // Unknown word: flagged, no architectural change
                        next_st.last_instr = instr;
                        next_st.bad_op = 1'b1;
                    end
                end
                ADDR_WREG: begin
                    if (st.w_strb[0]) begin
                        next_st.wreg = st.w_data[7:0];
                    end
                end
                ADDR_STATUS: begin
                    if (st.w_strb[0]) begin
                        next_st.carry = st.w_data[STAT_C_BIT];
                        next_st.zero = st.w_data[STAT_Z_BIT];
                        next_st.neg = st.w_data[STAT_N_BIT];
                    end
                end
                ADDR_BANK: begin
                    if (st.w_strb[0]) begin
                        next_st.bank = st.w_data[3:0];
                    end
                end
                ADDR_CFG: begin
                    if (st.w_strb[0]) begin
                        next_st.ext_en = st.w_data[CFG_EXT_BIT];
                    end
                end
                ADDR_INDEX: begin
                    if (st.w_strb[0]) begin
                        next_st.index_base[7:0] = st.w_data[7:0];
                    end
                    if (st.w_strb[1]) begin
                        next_st.index_base[11:8] = st.w_data[11:8];
                    end
                end
                ADDR_MEM_ADDR: begin
                    if (st.w_strb[0]) begin
                        next_st.mem_addr[7:0] = st.w_data[7:0];
                    end
                    if (st.w_strb[1]) begin
                        next_st.mem_addr[11:8] = st.w_data[11:8];
                    end
                end
                ADDR_MEM_DATA: begin
                    mem_waddr = st.mem_addr;
                    mem_wdata = st.w_data[7:0];
                    mem_we = st.w_strb[0];
                end
                default: begin
                    next_st.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            next_st.rdata = 32'h0000_0000;
            case ({s_axi_araddr[7:2], 2'b00})
                ADDR_INSTR: next_st.rdata[15:0] = st.last_instr;
                ADDR_WREG: next_st.rdata[7:0] = st.wreg;
                ADDR_STATUS: next_st.rdata[7:0] = status_byte;
                ADDR_BANK: next_st.rdata[3:0] = st.bank;
                ADDR_CFG: next_st.rdata[CFG_EXT_BIT] = st.ext_en;
                ADDR_INDEX: next_st.rdata[11:0] = st.index_base;
                ADDR_MEM_ADDR: next_st.rdata[11:0] = st.mem_addr;
                ADDR_MEM_DATA: next_st.rdata[7:0] = mem_rdata;
                default: next_st.rresp = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st <= '0;
            st.last_instr <= INSTR_RST;
            st.wreg <= WREG_RST;
            st.bank <= BANK_RST;
            st.ext_en <= CFG_EXT_RST;
            st.index_base <= INDEX_RST;
            st.mem_addr <= MEM_ADDR_RST;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus outputs; readies decoded from state, valids and data registered
    assign s_axi_awready = !st.aw_held && !st.bvalid;
    assign s_axi_wready = !st.w_held && !st.bvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    sequence s_instr_taken;
        instr_taken;
    endsequence

    sequence s_resp_ok;
        st.bvalid && (st.bresp == RESP_OKAY);
    endsequence

    property p_rl_flags;
        exec_fire && is_rl |=> st.neg == $past(src_data[6])
            && st.zero == ($past(src_data) == 8'h00);
    endproperty
    a_rl_flags: assert property (p_rl_flags)
        else $error("Left rotate flags wrong");

    property p_rl_to_w;
        exec_fire && is_rl && !dest_file
            |=> st.wreg == {$past(src_data[6:0]), $past(src_data[7])};
    endproperty
    a_rl_to_w: assert property (p_rl_to_w)
        else $error("Left rotate result wrong");

    property p_dest_file;
        exec_fire && dest_file |-> mem_we && (mem_waddr == eff_addr)
            && (mem_wdata == rot_result) ##1 $stable(st.wreg);
    endproperty
    a_dest_file: assert property (p_dest_file)
        else $error("File destination not honoured");

    property p_access_bank;
        exec_fire && !bank_sel && !st.ext_en |-> eff_addr == ((f_addr <= ACCESS_SPLIT)
            ? {ACCESS_LOW_PAGE, f_addr} : {ACCESS_HIGH_PAGE, f_addr});
    endproperty
    a_access_bank: assert property (p_access_bank)
        else $error("Access bank address wrong");

    property p_banked;
        exec_fire && bank_sel |-> (eff_addr[11:8] == st.bank) && (eff_addr[7:0] == f_addr);
    endproperty
    a_banked: assert property (p_banked)
        else $error("Banked address wrong");

    property p_indexed;
        exec_fire && !bank_sel && st.ext_en && (f_addr <= ACCESS_SPLIT)
            |-> eff_addr == 12'(st.index_base + {4'h0, f_addr});
    endproperty
    a_indexed: assert property (p_indexed)
        else $error("Indexed offset address wrong");

    property p_rr;
        exec_fire && is_rr && !dest_file |=> st.carry == $past(src_data[0])
            && st.wreg == {$past(st.carry), $past(src_data[7:1])};
    endproperty
    a_rr: assert property (p_rr)
        else $error("Right rotate through carry wrong");

    property p_one_cycle;
        s_instr_taken |=> s_resp_ok;
    endproperty
    a_one_cycle: assert property (p_one_cycle)
        else $error("Rotate did not finish in one cycle");

    property p_bad_op;
        instr_taken && !exec_fire |=> st.bad_op && $stable(st.wreg) && $stable(st.carry);
    endproperty
    a_bad_op: assert property (p_bad_op)
        else $error("Unknown word changed state");

endmodule : brot_core

// ### test/tb.sv
`timescale 1ns/1ps
module tb
    import brot_pkg::*;
;
    logic clk;
    logic resetn;
    logic [7:0] awaddr, araddr;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int fails, cmp_count;
    integer seed;

    brot_core i_brot_core (
        .clk(clk), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task results;
        begin
            $display("fails %0d comparisons %0d", fails, cmp_count);
            if (fails == 0 && cmp_count > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask : results

    task timed_out;
        begin
            fails++;
            $display("ERROR %0t bus handshake never completed", $time);
            results();
        end
    endtask : timed_out

    task chk_data(input logic [31:0] got, input logic [31:0] exp);
        begin
            cmp_count++;
            if (got !== exp) begin
                fails++;
                $display("ERROR %0t data %h expected %h", $time, got, exp);
            end
        end
    endtask : chk_data

    task chk_resp(input logic [1:0] got, input logic [1:0] exp);
        begin
            cmp_count++;
            if (got !== exp) begin
                fails++;
                $display("ERROR %0t response %h expected %h", $time, got, exp);
            end
        end
    endtask : chk_resp

    ////////////////////////////////////////////////////////////////////////////
    // Address and data offered together, each dropped when its own ready is seen
    // Handshakes sampled at the falling edge, where readies have settled
    task axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
             output logic [1:0] r);
        int n;
        logic ad, wd, bd, ag, wg;
        begin
            ad = 1'b0;
            wd = 1'b0;
            bd = 1'b0;
            n = 0;
            r = 2'h3;
            @(posedge clk);
            awaddr <= a;
            wdata <= d;
            wstrb <= s;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            while (!bd && n < 100) begin
                @(negedge clk);
                n++;
                ag = !ad && awvalid && awready;
                wg = !wd && wvalid && wready;
                if (ad && wd && bvalid) begin
                    bd = 1'b1;
                    r = bresp;
                end
                @(posedge clk);
                if (ag) begin
                    ad = 1'b1;
                    awvalid <= 1'b0;
                end
                if (wg) begin
                    wd = 1'b1;
                    wvalid <= 1'b0;
                end
                if (bd) begin
                    bready <= 1'b0;
                end
            end
            if (!bd) timed_out();
        end
    endtask : axw

    task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        logic ag, got;
        begin
            n = 0;
            got = 1'b0;
            d = 32'h0000_0000;
            r = 2'h3;
            @(posedge clk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            while (!got && n < 100) begin
                @(negedge clk);
                n++;
                ag = arvalid && arready;
                if (rvalid) begin
                    got = 1'b1;
                    d = rdata;
                    r = rresp;
                end
                @(posedge clk);
                if (ag) begin
                    arvalid <= 1'b0;
                end
                if (got) begin
                    rready <= 1'b0;
                end
            end
            if (!got) timed_out();
        end
    endtask : axr

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        begin
            axw(a, d, 4'hF, r);
            chk_resp(r, RESP_OKAY);
        end
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        begin
            axr(a, d, r);
            chk_resp(r, er);
            chk_data(d, exp);
        end
    endtask : rd

    ////////////////////////////////////////////////////////////////////////////
    // Effective byte address of the operand
    function automatic logic [11:0] eaddr(logic [15:0] ins, logic ext, logic [3:0] bk,
                                          logic [11:0] ix);
        logic [7:0] f;
        begin
            f = ins[7:0];
            if (ins[8]) return {bk, f};
            if (f <= 8'h5F) return ext ? ix + {4'h0, f} : {4'h0, f};
            return {4'hF, f};
        end
    endfunction : eaddr

    // Returns {carry, result}
    function automatic logic [8:0] rot(logic right, logic [7:0] v, logic c);
        begin
            if (right) return {v[0], c, v[7:1]};
            return {c, v[6:0], v[7]};
        end
    endfunction : rot

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] ins;
    logic [7:0] w, v, st, res;
    logic [3:0] bk;
    logic [11:0] ix, ea;
    logic ext, right, cout;
    logic [1:0] r;

    initial begin
        seed = 32'h105AF2DF;
        fails = 0;
        cmp_count = 0;
        resetn = 1'b0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        // Reset values
        rd(ADDR_INSTR, 32'h0, RESP_OKAY);
        rd(ADDR_MEM_ADDR, 32'h0, RESP_OKAY);
        rd(ADDR_WREG, 32'h0, RESP_OKAY);
        rd(ADDR_STATUS, 32'h0, RESP_OKAY);
        rd(ADDR_BANK, 32'h0, RESP_OKAY);
        rd(ADDR_CFG, 32'h0, RESP_OKAY);
        rd(ADDR_INDEX, 32'h0, RESP_OKAY);
        $display("test reset values done");
        // Refused accesses
        axw(8'h20, 32'hFFFFFFFF, 4'hF, r);
        chk_resp(r, RESP_SLVERR);
        rd(8'h20, 32'h0, RESP_SLVERR);
        axw(ADDR_INSTR, 32'h00004700, 4'h1, r);
        chk_resp(r, RESP_SLVERR);
        wr(ADDR_WREG, 32'h000000A5);
        wr(ADDR_INSTR, 32'h0000FFFF);
        rd(ADDR_STATUS, 32'h00000080, RESP_OKAY);
        rd(ADDR_WREG, 32'h000000A5, RESP_OKAY);
        $display("test refused accesses done");
        // Random rotates with boundary cases mixed in
        for (int i = 0; i < 48; i++) begin
            right = 1'($random(seed));
            ins = 16'($random(seed));
            ins[15:10] = right ? OPC_ROTATE_RIGHT_THRU_CARRY : OPC_ROTATE_LEFT_NO_CARRY;
            ext = 1'($random(seed));
            bk = 4'($random(seed));
            ix = 12'($random(seed));
            w = 8'($random(seed));
            v = 8'($random(seed));
            st = 8'($random(seed)) & 8'h15;
            // Split point, wrap of index and zero results are the awkward cases
            case (i % 6)
                0: ins[8:0] = {1'b0, 8'h5F};
                1: ins[8:0] = {1'b0, 8'h60};
                2: v = (right && !st[0]) ? 8'h01 : 8'h00;
                3: begin
                    ins[8:0] = {1'b0, 8'h5F};
                    ix = 12'hFFF;
                end
                default: ;
            endcase
            ea = eaddr(ins, ext, bk, ix);
            wr(ADDR_CFG, {31'h0, ext});
            wr(ADDR_BANK, {28'h0, bk});
            wr(ADDR_INDEX, {20'h0, ix});
            wr(ADDR_WREG, {24'h0, w});
            wr(ADDR_STATUS, {24'h0, st});
            wr(ADDR_MEM_ADDR, {20'h0, ea});
            wr(ADDR_MEM_DATA, {24'h0, v});
            wr(ADDR_INSTR, {16'h0, ins});
            {cout, res} = rot(right, v, st[0]);
            rd(ADDR_WREG, {24'h0, ins[9] ? w : res}, RESP_OKAY);
            rd(ADDR_MEM_DATA, {24'h0, ins[9] ? res : v}, RESP_OKAY);
            rd(ADDR_STATUS, {27'h0, res[7], 1'b0, res == 8'h00, 1'b0, cout},
               RESP_OKAY);
            rd(ADDR_INSTR, {16'h0, ins}, RESP_OKAY);
        end
        $display("test random rotates done");
        results();
    end
endmodule : tb
